// ==== common/mbs_pkg.sv ====
// Constants and carrier types of the message buffer search engine
// Behaviour
// - Owner code 000 means unassigned buffers, 001 module one, 010 module two.
// - Only buffers owned by the selected module take part in the search.
// - Start index sits in bits 5..0; software writes 0 to 31.
// - Scan runs from start index up to the highest buffer; lower ones ignored.
// - With several matches the lowest matching buffer number is reported.
// - Writing the start register launches a search; result then shows its outcome.
// - Result register is read-only, 16 bits wide; only a start-register write at its offset changes it.
// - Bits 9..8 give hits: x0 none, 01 exactly one, 11 several.
// - Bits 5..0 hold the found buffer number, 0 to 31.
// - Several matches set the multi flag yet still report the lowest number.
// - Start register is write-only, same offset as result, 16-bit writes.
// - Start bit 15 set lets only buffers without the standard-identifier flag match.
// - Start bit 11 set lets only buffers with new data flag match.
`default_nettype none

package mbs_pkg;

	// ==========================================================
	// Bus and map
	localparam int unsigned         MBS_ADDR_W       = 16;
	localparam int unsigned         MBS_DATA_W       = 16;
	localparam logic [15:0]         MBS_SEARCH_OFS   = 16'h041a;
	localparam int unsigned         MBS_NUM_BUF      = 32;

	// ==========================================================
	// Start register fields
	localparam int unsigned         MBS_START_LSB    = 0;
	localparam int unsigned         MBS_OWNER_LSB    = 8;
	localparam int unsigned         MBS_CHK_NEW_BIT  = 11;
	localparam int unsigned         MBS_CHK_STD_BIT  = 15;

	// ==========================================================
	// Result register fields
	localparam int unsigned         MBS_FOUND_LSB    = 0;
	localparam int unsigned         MBS_ANY_BIT      = 8;
	localparam int unsigned         MBS_MULTI_BIT    = 9;
	localparam logic [15:0]         MBS_RESULT_RST   = 16'h0000;

	// ==========================================================
	// Owner codes
	localparam logic [2:0]          MBS_OWN_NONE     = 3'h0;
	localparam logic [2:0]          MBS_OWN_MOD1     = 3'h1;
	localparam logic [2:0]          MBS_OWN_MOD2     = 3'h2;

	typedef struct packed {
		logic [2:0] owner;
		logic       std_id;
		logic       new_data_flag;
	} mbs_buf_t;

	typedef struct packed {
		logic       multi_hit;
		logic       any_hit;
		logic [5:0] found_index;
	} mbs_result_t;

endpackage

`default_nettype wire

// ==== core/mbs_search.sv ====
// Message buffer search engine with its register port
`default_nettype none

module mbs_search
	import mbs_pkg::*;
#(
	parameter int unsigned NUM_BUF = MBS_NUM_BUF
) (
	input  wire logic                  clk_sys,
	input  wire logic                  sys_rst,
	input  wire logic [MBS_ADDR_W-1:0] reg_addr,
	input  wire logic [MBS_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [MBS_DATA_W-1:0] reg_rdata,
	input  wire mbs_buf_t [NUM_BUF-1:0] buf_stat
);

	// ==========================================================
	// Helpers
	function automatic logic owner_valid(input logic [2:0] sel);
		owner_valid = (sel == MBS_OWN_NONE) || (sel == MBS_OWN_MOD1) ||
			(sel == MBS_OWN_MOD2);
	endfunction

	function automatic logic buf_match(input mbs_buf_t b, input logic [15:0] crit);
		logic [2:0] sel;
		sel = crit[MBS_OWNER_LSB +: 3];
		buf_match = owner_valid(sel) && (b.owner == sel) &&
			(!crit[MBS_CHK_STD_BIT] || !b.std_id) &&
			(!crit[MBS_CHK_NEW_BIT] || b.new_data_flag);
	endfunction

	function automatic logic [NUM_BUF-1:0] low_mask(input logic [5:0] idx);
		logic [NUM_BUF-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_BUF; i++) begin
			if (i < int'(idx)) begin
				m[i] = 1'b1;
			end
		end
		low_mask = m;
	endfunction

	// ==========================================================
	// Search decode
	logic                sel_search;
	logic                wr_search;
	logic [NUM_BUF-1:0]  hit_vec;
	mbs_result_t         res_calc;
	logic [5:0]          start_idx;

	assign sel_search = (reg_addr == MBS_SEARCH_OFS);
	assign wr_search  = reg_wr && sel_search;
	assign start_idx  = reg_wdata[MBS_START_LSB +: 6];

	// Whole scan in one cycle: no busy state for software to poll
	always_comb begin
		int unsigned n;
		n        = 0;
		hit_vec  = '0;
		res_calc = '0;
		for (int i = 0; i < NUM_BUF; i++) begin
			hit_vec[i] = (i >= int'(start_idx)) && buf_match(buf_stat[i], reg_wdata);
		end
		for (int i = NUM_BUF - 1; i >= 0; i--) begin
			if (hit_vec[i]) begin
				res_calc.found_index = 6'(i);
			end
		end
		for (int i = 0; i < NUM_BUF; i++) begin
			if (hit_vec[i]) begin
				n = n + 1;
			end
		end
		res_calc.any_hit   = (n != 0);
		res_calc.multi_hit = (n > 1);
	end

	// ==========================================================
	// Result and read data
	mbs_result_t         result_q;
	mbs_result_t         result_d;
	logic [15:0]         rdata_q;
	logic [15:0]         rdata_d;

	always_comb begin
		result_d = result_q;
		if (wr_search) begin
			result_d = res_calc;
		end
	end

	// Bits 7 and 6 and unmapped reads return zero
	always_comb begin
		rdata_d = '0;
		if (reg_rd && sel_search) begin
			rdata_d[MBS_FOUND_LSB +: 6] = result_q.found_index;
			rdata_d[MBS_ANY_BIT]        = result_q.any_hit;
			rdata_d[MBS_MULTI_BIT]      = result_q.multi_hit;
		end
	end

	// Hit vector of the last cycle, kept only for the checks below
	logic [NUM_BUF-1:0]  hit_prev_q;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			result_q.multi_hit   <= MBS_RESULT_RST[MBS_MULTI_BIT];
			result_q.any_hit     <= MBS_RESULT_RST[MBS_ANY_BIT];
			result_q.found_index <= MBS_RESULT_RST[MBS_FOUND_LSB +: 6];
			rdata_q              <= '0;
			hit_prev_q           <= '0;
		end else begin
			result_q   <= result_d;
			rdata_q    <= rdata_d;
			hit_prev_q <= hit_vec;
		end
	end

	assign reg_rdata = rdata_q;

	// ==========================================================
	// Checks
	hit_code_legal_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!(result_q.multi_hit && !result_q.any_hit))
		else $error("multi flag without any-hit flag");

	found_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		int'(result_q.found_index) < int'(NUM_BUF))
		else $error("found index out of range");

	rd_latency_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(reg_rd && sel_search) |=> (reg_rdata == {6'h00, result_q.multi_hit,
			result_q.any_hit, 2'b00, result_q.found_index}))
		else $error("result read data wrong");

	start_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_search |=> (!result_q.any_hit ||
			result_q.found_index >= $past(reg_wdata[5:0])))
		else $error("hit below start index");

	found_match_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_search |=> (!result_q.any_hit ||
			hit_prev_q[result_q.found_index[4:0]]))
		else $error("reported buffer does not match");

	bad_owner_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(wr_search && !owner_valid(reg_wdata[10:8])) |=> !result_q.any_hit)
		else $error("invalid owner code produced a hit");

	hold_result_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!wr_search |=> $stable(result_q))
		else $error("result changed without a search");

	lowest_hit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_search |=> (($past(hit_vec) & low_mask(result_q.found_index)) == '0))
		else $error("lower matching buffer skipped");

	multi_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_search |=> (result_q.multi_hit == ($countones($past(hit_vec)) > 1)))
		else $error("multi flag disagrees with hit count");

	search_done_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_search ##1 (reg_rd && sel_search) |=> reg_rdata[8] == ($past(hit_vec, 2) != '0))
		else $error("read returned stale result");

endmodule

`default_nettype wire

// ==== test/mbs_search_test.sv ====
// Self-checking bench of the message buffer search engine
`default_nettype none

module mbs_search_test
	import mbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Clock, reset, ports
	logic                            clk_sys = 1'b0;
	logic                            sys_rst = 1'b1;
	logic [MBS_ADDR_W-1:0]           reg_addr = 16'h0000;
	logic [MBS_DATA_W-1:0]           reg_wdata = 16'h0000;
	logic                            reg_wr = 1'b0;
	logic                            reg_rd = 1'b0;
	logic [MBS_DATA_W-1:0]           reg_rdata;
	mbs_buf_t [MBS_NUM_BUF-1:0]      buf_stat;
	int                              n_fail = 0;
	int                              n_tests = 0;
	logic [15:0]                     w;
	logic [15:0]                     d;
	localparam logic [5:0]           STARTS [4] = '{6'h00, 6'h07, 6'h1e, 6'h1f};

	always #5 clk_sys = ~clk_sys;

	mbs_search #(.NUM_BUF(MBS_NUM_BUF)) u_dut (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.buf_stat  (buf_stat)
	);

	// ==========================================================
	// Bus tasks and checks
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// Data is only valid in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	// Reference scan, kept independent of the design's own code
	function automatic logic [15:0] ref_res(input logic [15:0] v);
		logic [15:0] r;
		logic        hit;
		r = 16'h0000;
		for (int i = 0; i < MBS_NUM_BUF; i++) begin
			hit = (i >= int'(v[5:0])) && (buf_stat[i].owner == v[10:8]) && (v[10:8] <= 3'h2)
				&& !(v[15] && buf_stat[i].std_id) && !(v[11] && !buf_stat[i].new_data_flag);
			if (hit && r[8])
				r[9] = 1'b1;
			if (hit && !r[8])
				r = 16'h0100 | 16'(i);
		end
		return r;
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// Buffer pattern; top buffer carries an unlisted owner code
	initial begin
		for (int i = 0; i < MBS_NUM_BUF; i++)
			buf_stat[i] = '{owner: 3'(i % 3), std_id: i[2], new_data_flag: i[3]};
		buf_stat[31].owner = 3'h5;
	end

	// Generous bound: the sweep needs under 600 cycles
	initial begin
		#200us;
		n_fail++;
		print_verdict();
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(MBS_SEARCH_OFS, d);
		chk("reset result", MBS_RESULT_RST, d);
		for (int s = 0; s < 8; s++) begin
			for (int k = 0; k < 4; k++) begin
				for (int c = 0; c < 4; c++) begin
					w = {c[1], 3'h0, c[0], 3'(s), 2'h0, STARTS[k]};
					wr(MBS_SEARCH_OFS, w);
					rd(MBS_SEARCH_OFS, d);
					chk("search", ref_res(w), d);
				end
			end
		end
		w = 16'h0100;
		for (int n = 0; n < 33; n++) begin
			wr(MBS_SEARCH_OFS, w);
			rd(MBS_SEARCH_OFS, d);
			chk("next match", ref_res(w), d);
			if (d[8] !== 1'b1)
				break;
			w[5:0] = d[5:0] + 6'h01;
		end
		wr(MBS_SEARCH_OFS, 16'h0201);
		wr(16'h041c, 16'h0000);
		rd(MBS_SEARCH_OFS, d);
		chk("other write", ref_res(16'h0201), d);
		rd(16'h041c, d);
		chk("other read", 16'h0000, d);
		print_verdict();
	end

endmodule

`default_nettype wire
